// *** hdl/pmicio_map.vh ***
// constants for the pmic pin control and push-button block
`ifndef PMICIO_MAP_VH
`define PMICIO_MAP_VH
// register byte offsets
`define PMICIO_OFS_CTRL 4'h0
`define PMICIO_OFS_STAT 4'h4
`define PMICIO_OFS_IRQ 4'h8
`define PMICIO_OFS_VOLT 4'hc
// control register fields
`define PMICIO_CTRL_P1OUT 0
`define PMICIO_CTRL_RSTOUT 1
`define PMICIO_CTRL_P3OUT 2
`define PMICIO_CTRL_P1SEL 3
`define PMICIO_CTRL_BUFT 4
`define PMICIO_CTRL_CRSTEN 5
`define PMICIO_CTRL_TRST 6
`define PMICIO_CTRL_PBM 7
`define PMICIO_CTRL_RESET 8'h03
// status register fields
`define PMICIO_STAT_PBLVL 0
`define PMICIO_STAT_ACTIVE 1
`define PMICIO_STAT_RECOV 2
`define PMICIO_STAT_POWER_GOOD 3
// voltage register reset values (core bucks)
`define PMICIO_VOLT_DEF1 6'h00
`define PMICIO_VOLT_DEF2 6'h00
// timing
`define PMICIO_TICK_HZ 32768
`define PMICIO_CLK_HZ 50000000
`define PMICIO_PWRUP_MS 600
`define PMICIO_LONG_MS 8000
`define PMICIO_XLONG_MS 15000
`define PMICIO_DOWN_MS 500
`define PMICIO_WAKE_TICKS 5
`define PMICIO_REASSERT_US 32
`define PMICIO_TICK_DIV (`PMICIO_CLK_HZ / `PMICIO_TICK_HZ)
`endif

// *** hdl/pmicio_top.v ***
// pin control, push-button monitor and register slave of the pmic
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
// Function
// - pin one open-drain out of its bit
// - select one: reset output copies pin one
// - power good low: hold level, else copy pin one
// - select zero: reset output follows its bit
// - select one: reset output ignores its bit
// - pin three open-drain out, sequencer may drive
// - pin three fall resets core voltage registers
// - core bucks slew back without power cycle
// - power-up after 600 ms button low
// - active: irq on each button edge
// - button mask suppresses change interrupt
// - status shows present button level
// - wake request low five slow ticks
// - long press disables rails, recovery state
// - restart after 500 ms power-down
// - held button repeats reset cycle
// - irq pin low; read clears, reasserts
// - mask gates only the irq pin
`include "pmicio_map.vh"
module pmicio_top
#(
   parameter PWRUP_TICKS = (`PMICIO_PWRUP_MS * `PMICIO_TICK_HZ + 999) / 1000,
   parameter LONG_TICKS = (`PMICIO_LONG_MS * `PMICIO_TICK_HZ + 999) / 1000,
   parameter XLONG_TICKS = (`PMICIO_XLONG_MS * `PMICIO_TICK_HZ + 999) / 1000,
   parameter DOWN_TICKS = (`PMICIO_DOWN_MS * `PMICIO_TICK_HZ + 999) / 1000,
   parameter TICK_DIV = `PMICIO_TICK_DIV
)
(
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // avalon-mm slave
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // pins
   input wire io_pin_one_in,
   output reg io_pin_one_out,
   output reg io_pin_one_oe,
   output reg memory_reset_output_out,
   output reg memory_reset_output_oe,
   input wire io_pin_three_in,
   output reg io_pin_three_out,
   output reg io_pin_three_oe,
   input wire push_button,
   output reg wake_request_n,
   output reg irq_n_out,
   output reg irq_n_oe,
   // system
   input wire power_good,
   input wire seq_pin_three_low,
   output reg rails_enable,
   output reg backup_enable,
   output reg [5:0] core_buck_one_volt,
   output reg [5:0] core_buck_two_volt
);
   localparam ST_OFF = 4'h1;
   localparam ST_ACTIVE = 4'h2;
   localparam ST_DOWN = 4'h4;
   localparam ST_RECOV = 4'h8;
   localparam integer REASSERT_INT = (`PMICIO_REASSERT_US * 50) - 1;
   localparam [10:0] REASSERT_CYC = REASSERT_INT[10:0];
   localparam integer WAKE_INT = `PMICIO_WAKE_TICKS;
   localparam [2:0] WAKE_LEN = WAKE_INT[2:0];

   reg [7:0] ctrl;
   reg [3:0] state;
   reg pb_s1, pb_s2, pb_q;
   reg p1_s1, p1_s2;
   reg p3_s1, p3_s2, p3_q;
   reg pg_s1, pg_s2;
   reg [10:0] div_cnt;
   reg tick;
   reg [19:0] low_cnt;
   reg [19:0] down_cnt;
   reg [2:0] wake_cnt;
   reg irq_pb;
   reg [10:0] rearm_cnt;
   reg rst_hold;
   reg next_rst_level;
   wire p1_sel = ctrl[`PMICIO_CTRL_P1SEL];
   wire buft = ctrl[`PMICIO_CTRL_BUFT];
   wire hit_rd = avs_read & avs_waitrequest;
   wire hit_wr = avs_write & avs_waitrequest;
   wire [19:0] long_lim = ctrl[`PMICIO_CTRL_TRST] ? XLONG_TICKS[19:0]
                                                 : LONG_TICKS[19:0];
   wire pb_edge = tick & (pb_s2 != pb_q);
   wire irq_rd = hit_rd & (avs_address == `PMICIO_OFS_IRQ);

   // ==================================================
   // synchronisers and slow tick
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pb_s1 <= 1'b1; pb_s2 <= 1'b1; pb_q <= 1'b1;
         p1_s1 <= 1'b0; p1_s2 <= 1'b0;
         p3_s1 <= 1'b1; p3_s2 <= 1'b1; p3_q <= 1'b1;
         pg_s1 <= 1'b0; pg_s2 <= 1'b0;
         div_cnt <= 11'h000;
         tick <= 1'b0;
      end
      else
      begin
         pb_s1 <= push_button;
         pb_s2 <= pb_s1;
         p1_s1 <= io_pin_one_in;
         p1_s2 <= p1_s1;
         p3_s1 <= io_pin_three_in;
         p3_s2 <= p3_s1;
         pg_s1 <= power_good;
         pg_s2 <= pg_s1;
         tick <= (div_cnt == TICK_DIV[10:0] - 11'h001);
         div_cnt <= (div_cnt == TICK_DIV[10:0] - 11'h001) ? 11'h000
                                                          : div_cnt + 11'h001;
         if (tick)
         begin
            pb_q <= pb_s2;
            p3_q <= p3_s2;
         end
      end
   end

   // ==================================================
   // reset output level
   always @*
   begin
      next_rst_level = rst_hold;
      if (pg_s2)
         next_rst_level = p1_s2;
   end

   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         rst_hold <= 1'b0;
      else
         rst_hold <= next_rst_level;
   end

   // ==================================================
   // state machine and timers
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= ST_OFF;
         low_cnt <= 20'h00000;
         down_cnt <= 20'h00000;
         wake_cnt <= 3'h0;
      end
      else
      begin
         if (tick)
         begin
            if (pb_q)
               low_cnt <= 20'h00000;
            else if (low_cnt != 20'hfffff)
               low_cnt <= low_cnt + 20'h00001;
            if (state == ST_ACTIVE && pb_edge && !pb_s2)
               wake_cnt <= WAKE_LEN;
            else if (wake_cnt != 3'h0)
               wake_cnt <= wake_cnt - 3'h1;
         end
         case (state)
            ST_OFF:
               if (tick && !pb_q && low_cnt == PWRUP_TICKS[19:0] - 20'h1)
                  state <= ST_ACTIVE;
            ST_ACTIVE:
               if (tick && !pb_q && low_cnt == long_lim - 20'h1)
               begin
                  state <= ST_DOWN;
                  down_cnt <= 20'h00000;
               end
            ST_DOWN:
               if (tick)
               begin
                  if (down_cnt == DOWN_TICKS[19:0] - 20'h1)
                  begin
                     state <= ST_RECOV;
                     low_cnt <= 20'h00000;
                  end
                  down_cnt <= down_cnt + 20'h00001;
               end
            ST_RECOV:
               state <= ST_ACTIVE;
            default:
               state <= ST_OFF;
         endcase
      end
   end

   // ==================================================
   // registers, irq and pins
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl <= `PMICIO_CTRL_RESET;
         avs_readdata <= 32'h00000000;
         avs_waitrequest <= 1'b1;
         irq_pb <= 1'b0;
         rearm_cnt <= 11'h000;
         irq_n_out <= 1'b0;
         irq_n_oe <= 1'b0;
         core_buck_one_volt <= `PMICIO_VOLT_DEF1;
         core_buck_two_volt <= `PMICIO_VOLT_DEF2;
         io_pin_one_out <= 1'b0;
         io_pin_one_oe <= 1'b0;
         memory_reset_output_out <= 1'b0;
         memory_reset_output_oe <= 1'b1;
         io_pin_three_out <= 1'b0;
         io_pin_three_oe <= 1'b0;
         wake_request_n <= 1'b1;
         rails_enable <= 1'b0;
         backup_enable <= 1'b1;
      end
      else
      begin
         avs_waitrequest <= ~(avs_read | avs_write) | ~avs_waitrequest;
         if (hit_wr && avs_address == `PMICIO_OFS_CTRL)
            ctrl <= avs_writedata[7:0];
         if (hit_wr && avs_address == `PMICIO_OFS_VOLT)
         begin
            core_buck_one_volt <= avs_writedata[5:0];
            core_buck_two_volt <= avs_writedata[13:8];
         end
         if (ctrl[`PMICIO_CTRL_CRSTEN] && tick && p3_q && !p3_s2)
         begin
            core_buck_one_volt <= `PMICIO_VOLT_DEF1;
            core_buck_two_volt <= `PMICIO_VOLT_DEF2;
         end
         if (hit_rd)
            case (avs_address)
               `PMICIO_OFS_CTRL: avs_readdata <= {24'h000000, ctrl};
               `PMICIO_OFS_STAT: avs_readdata <= {28'h0000000, pg_s2,
                  state == ST_RECOV, state == ST_ACTIVE, pb_q};
               `PMICIO_OFS_IRQ: avs_readdata <= {31'h0, irq_pb};
               `PMICIO_OFS_VOLT: avs_readdata <= {18'h0, core_buck_two_volt,
                  2'h0, core_buck_one_volt};
               default: avs_readdata <= 32'h00000000;
            endcase
         // set wins over read clear
         if (state == ST_ACTIVE && pb_edge)
            irq_pb <= 1'b1;
         else if (irq_rd)
            irq_pb <= 1'b0;
         // only a cause that persists through the read is held off
         if (irq_rd && state == ST_ACTIVE && pb_edge)
            rearm_cnt <= REASSERT_CYC;
         else if (rearm_cnt != 11'h000)
            rearm_cnt <= rearm_cnt - 11'h001;
         irq_n_oe <= irq_pb & ~ctrl[`PMICIO_CTRL_PBM] & ~irq_rd
                     & (rearm_cnt == 11'h000);
         io_pin_one_oe <= ~p1_sel & ~ctrl[`PMICIO_CTRL_P1OUT];
         if (p1_sel)
         begin
            memory_reset_output_out <= next_rst_level;
            memory_reset_output_oe <= buft | ~next_rst_level;
         end
         else
         begin
            memory_reset_output_out <= ctrl[`PMICIO_CTRL_RSTOUT];
            memory_reset_output_oe <= buft | ~ctrl[`PMICIO_CTRL_RSTOUT];
         end
         io_pin_three_oe <= ~ctrl[`PMICIO_CTRL_CRSTEN]
            & (~ctrl[`PMICIO_CTRL_P3OUT] | seq_pin_three_low);
         wake_request_n <= (wake_cnt == 3'h0);
         rails_enable <= (state == ST_ACTIVE);
         backup_enable <= 1'b1;
      end
   end
endmodule

// *** verification/pmicio_chk.sv ***
// port assertions of the pmic pin control block
`timescale 1ns/1ps
module pmicio_chk
#(
   parameter TICK_DIV = 4
)
(
   input wire clk_sys,
   input wire reset_n,
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   input wire io_pin_one_out,
   input wire io_pin_three_out,
   input wire irq_n_out,
   input wire wake_request_n,
   input wire rails_enable,
   input wire backup_enable
);
   reg [7:0] low_cnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // length of the wake request pulse
   always @(posedge clk_sys or negedge reset_n)
      if (!reset_n)
         low_cnt <= 8'h00;
      else
         low_cnt <= wake_request_n ? 8'h00 : low_cnt + 8'h01;
   a_pin_one_od: assert property (io_pin_one_out == 1'b0)
      else $error("pin one driven high");
   a_pin_three_od: assert property (io_pin_three_out == 1'b0)
      else $error("pin three driven high");
   a_irq_od: assert property (irq_n_out == 1'b0)
      else $error("irq pin driven high");
   a_backup_kept: assert property (backup_enable)
      else $error("backup rails off");
   a_wake_width: assert property ($rose(wake_request_n) |->
      low_cnt >= 5 * TICK_DIV - 1 && low_cnt <= 5 * TICK_DIV + 1)
      else $error("wake pulse width wrong");
   a_wake_active: assert property (!wake_request_n |-> rails_enable)
      else $error("wake pulse outside active");
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("bus answer late");
   a_bus_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_restart_due: assert property ($fell(rails_enable) |->
      ##[1:300] rails_enable) else $error("no restart");
endmodule

// *** verification/pmicio_far.sv ***
// push-button switch and host pin drivers at the far side
`timescale 1ns/1ps
module pmicio_far
(
   // bench commands
   input wire press,
   input wire host_p1,
   input wire host_p3,
   // pin enables of the block
   input wire p1_oe,
   input wire p3_oe,
   // resolved pin levels
   output wire push_button,
   output wire p1_in,
   output wire p3_in
);
   // switch to ground with pull-up; open-drain low wins over the host
   assign push_button = ~press;
   assign p1_in = p1_oe ? 1'b0 : host_p1;
   assign p3_in = p3_oe ? 1'b0 : host_p3;
endmodule

// *** verification/pmicio_top_tb.sv ***
// self-checking bench of the pmic pin control block
`timescale 1ns/1ps
`include "pmicio_map.vh"
module pmicio_top_tb;
   reg clk_sys = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   reg [3:0] avs_address = 4'h0;
   reg [31:0] avs_writedata = 32'h0, q, v;
   reg power_good = 1'b0, seq_pin_three_low = 1'b0, press = 1'b0;
   reg host_p1 = 1'b1, host_p3 = 1'b1;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, io_pin_one_in, io_pin_one_out, io_pin_one_oe;
   wire memory_reset_output_out, memory_reset_output_oe, io_pin_three_in;
   wire io_pin_three_out, io_pin_three_oe, push_button, wake_request_n;
   wire irq_n_out, irq_n_oe, rails_enable, backup_enable;
   wire [5:0] core_buck_one_volt, core_buck_two_volt;
   integer n_errors = 0, samples_checked = 0, cyc = 0, i;
   pmicio_top #(.PWRUP_TICKS(10), .LONG_TICKS(40), .XLONG_TICKS(60),
      .DOWN_TICKS(8), .TICK_DIV(4)) dut (.clk_sys, .reset_n, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .io_pin_one_in, .io_pin_one_out, .io_pin_one_oe, .memory_reset_output_out,
      .memory_reset_output_oe, .io_pin_three_in, .io_pin_three_out,
      .io_pin_three_oe, .push_button, .wake_request_n, .irq_n_out, .irq_n_oe,
      .power_good, .seq_pin_three_low, .rails_enable, .backup_enable,
      .core_buck_one_volt, .core_buck_two_volt);
   pmicio_far far (.press, .host_p1, .host_p3, .p1_oe(io_pin_one_oe),
      .p3_oe(io_pin_three_oe), .push_button, .p1_in(io_pin_one_in),
      .p3_in(io_pin_three_in));
   initial forever #10 clk_sys = ~clk_sys;
   task chk(input [31:0] got, input [31:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task bus(input w, input [3:0] a, input [31:0] d);
   begin
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= ~w;
      avs_write <= w;
      avs_writedata <= d;
      // hold the request until waitrequest is sampled low at a rising edge
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk_sys);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   end
   endtask
   task wt(input integer n);
      repeat (n) @(posedge clk_sys);
   endtask
   task waitr(input lvl);
      integer j;
   begin
      for (j = 0; j < 600 && rails_enable !== lvl; j = j + 1)
         @(posedge clk_sys);
      chk(rails_enable, lvl);
   end
   endtask
   task summarize;
   begin
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors = n_errors + 1;
         summarize;
      end
   end
   // ========================================
   // main sequence
   initial
   begin
      v = $urandom(32'h94fb);
      wt(2);
      reset_n <= 1'b1;
      bus(0, `PMICIO_OFS_CTRL, 0);
      chk(q, `PMICIO_CTRL_RESET);
      bus(1, 4'h1, $urandom);
      bus(0, 4'h1, 0);
      chk(q, 0);
      bus(1, `PMICIO_OFS_CTRL, 32'h00);
      wt(2);
      chk({io_pin_one_oe, io_pin_three_oe}, 2'b11);
      seq_pin_three_low <= 1'b1;
      bus(1, `PMICIO_OFS_CTRL, 32'h05);
      wt(2);
      chk({io_pin_one_oe, io_pin_three_oe}, 2'b01);
      seq_pin_three_low <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
      begin
         bus(1, `PMICIO_OFS_CTRL, 32'h05 | (i[1] << 4) | (i[0] << 1));
         wt(2);
         chk({memory_reset_output_oe, memory_reset_output_oe &
            memory_reset_output_out}, {i[1] | ~i[0], i[1] & i[0]});
      end
      bus(1, `PMICIO_OFS_CTRL, 32'h19 | ($urandom & 32'h2));
      wt(4);
      chk({io_pin_one_oe, memory_reset_output_oe, memory_reset_output_out},
         3'b010);
      power_good <= 1'b1;
      for (i = 0; i < 2; i = i + 1)
      begin
         host_p1 <= i[0];
         wt(5);
         chk(memory_reset_output_out, i[0]);
      end
      power_good <= 1'b0;
      wt(5);
      host_p1 <= 1'b0;
      wt(5);
      chk(memory_reset_output_out, 1'b1);
      host_p1 <= 1'b1;
      // too short a press must not power up
      press <= 1'b1;
      wt(24);
      press <= 1'b0;
      wt(60);
      chk(rails_enable, 1'b0);
      press <= 1'b1;
      waitr(1'b1);
      press <= 1'b0;
      wt(30);
      bus(0, `PMICIO_OFS_IRQ, 0);
      for (i = 0; i < 2; i = i + 1)
      begin
         press <= ~i[0];
         wt(30);
         chk(irq_n_oe, 1'b1);
         bus(0, `PMICIO_OFS_STAT, 0);
         chk(q[1:0], {1'b1, i[0]});
         bus(0, `PMICIO_OFS_IRQ, 0);
         chk(q[0], 1'b1);
         bus(0, `PMICIO_OFS_IRQ, 0);
         chk({irq_n_oe, q[0]}, 2'b00);
      end
      bus(1, `PMICIO_OFS_CTRL, 32'h99);
      press <= 1'b1;
      wt(30);
      chk(irq_n_oe, 1'b0);
      bus(0, `PMICIO_OFS_IRQ, 0);
      chk(q[0], 1'b1);
      press <= 1'b0;
      wt(30);
      bus(0, `PMICIO_OFS_IRQ, 0);
      bus(1, `PMICIO_OFS_CTRL, 32'hb9);
      v = $urandom & 32'h3f3f;
      bus(1, `PMICIO_OFS_VOLT, v);
      bus(0, `PMICIO_OFS_VOLT, 0);
      chk(q, v);
      host_p3 <= 1'b0;
      wt(30);
      bus(0, `PMICIO_OFS_VOLT, 0);
      chk(q, {`PMICIO_VOLT_DEF2, 2'b00, `PMICIO_VOLT_DEF1});
      chk({io_pin_three_oe, core_buck_one_volt}, `PMICIO_VOLT_DEF1);
      bus(0, `PMICIO_OFS_CTRL, 0);
      chk(q, 32'hb9);
      host_p3 <= 1'b1;
      press <= 1'b1;
      for (i = 0; i < 2; i = i + 1)
      begin
         waitr(1'b0);
         waitr(1'b1);
      end
      press <= 1'b0;
      summarize;
   end
endmodule
bind pmicio_top pmicio_chk #(.TICK_DIV(TICK_DIV)) chk_i (.clk_sys, .reset_n,
   .avs_read, .avs_write, .avs_waitrequest, .io_pin_one_out, .io_pin_three_out,
   .irq_n_out, .wake_request_n, .rails_enable, .backup_enable);
